/* File: inc/pcr_defines.svh */
// register offsets, field positions and reset values of the processor control register bank
`ifndef PCR_DEFINES_SVH
`define PCR_DEFINES_SVH
`define PCR_OFF_STATUS 12'h000
`define PCR_OFF_CONFIG 12'h004
`define PCR_OFF_XADDR 12'h008
`define PCR_OFF_XDATA 12'h00c
`define PCR_RELEASE_LEVEL 8'h01
`define PCR_CFG_WMASK 32'h0000_00ff
`define PCR_CFG_RESET 8'h01
`define PCR_STS_WMASK 32'h0000_040f
`define PCR_STS_RESET 11'h000
`define PCR_RESP_OKAY 2'b00
`define PCR_RESP_SLVERR 2'b10
`endif

/* File: inc/pcr_pkg.sv */
// types of the processor control register bank
package pcr_pkg;
    typedef struct packed {
        logic early_load_en;
        logic jump_cache_layout;
        logic narrow_access_en;
        logic vector_table_mode;
        logic handler_rom_sel;
        logic byte_order_sel;
        logic coproc_present;
        logic jump_cache_off;
    } pcr_cfg_t;
    typedef struct packed {
        logic valid;
        logic is_load;
        logic to_coproc;
        logic xlate_en;
        logic [31:0] vaddr;
        logic [31:0] paddr;
        logic [31:0] data;
    } pcr_xfer_t;
    typedef struct packed {
        logic irq_taken;
        logic trap_taken;
        logic urgent_trap;
        logic ext_trap;
        logic breakpoint;
        logic branch_exec;
    } pcr_evt_t;
    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic aw_held;
        logic [11:0] aw_addr;
        logic w_held;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic freeze_flag;
        logic [1:0] interrupt_priority_mask;
        logic ext_irq_mask_all;
        logic global_event_block;
        pcr_cfg_t cfg;
        logic jump_cache_off_eff;
        logic [31:0] xfer_addr_capture;
        logic [31:0] xfer_data_capture;
        logic [3:0] irq_enable;
        logic irq_take;
        logic trap_take;
        logic monitor_enter;
        logic user_check;
        logic coproc_trap;
        logic narrow_hw;
        logic [3:0] irq_s1;
        logic [3:0] irq_s2;
        logic [3:0] irq_s3;
        logic [3:0] irq_lvl;
    } pcr_state_t;
endpackage

/* File: logic/pcr_bank.sv */
// processor control registers: status low bits, configuration and transfer capture
//
// Implementation choices: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "pcr_defines.svh"
module pcr_bank (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [11:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [3:0] ext_irq_lines,
    input wire logic trap_req,
    input wire logic urgent_trap,
    input wire logic ext_trap,
    input wire logic timer_irq,
    input wire logic trace_trap,
    input wire logic breakpoint,
    input wire logic branch_exec,
    input wire logic user_rights_override,
    input wire logic ldst_coproc,
    input wire logic ldst_narrow,
    input wire pcr_pkg::pcr_xfer_t xfer,
    output pcr_pkg::pcr_cfg_t cfg_out,
    output logic jump_cache_off_eff,
    output logic [3:0] irq_enable,
    output logic irq_take,
    output logic trap_take,
    output logic monitor_enter,
    output logic user_check,
    output logic coproc_trap,
    output logic narrow_hw,
    output logic freeze_flag
);
    import pcr_pkg::*;

    pcr_state_t s_reg;
    pcr_state_t s_next;

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                          input logic [3:0] st);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++)
        begin
            if (st[i])
            begin
                r[i*8 +: 8] = wd[i*8 +: 8];
            end
        end
        return r;
    endfunction

    function automatic logic [31:0] read_word(input pcr_state_t s, input logic [11:0] a);
        logic [31:0] r;
        r = 32'h0000_0000;
        unique case (a)
            `PCR_OFF_STATUS: r = {21'h000000, s.freeze_flag, 6'h00,
                                  s.interrupt_priority_mask, s.ext_irq_mask_all,
                                  s.global_event_block};
            `PCR_OFF_CONFIG: r = {`PCR_RELEASE_LEVEL, 16'h0000, s.cfg};
            `PCR_OFF_XADDR: r = s.xfer_addr_capture;
            `PCR_OFF_XDATA: r = s.xfer_data_capture;
            default: r = 32'h0000_0000;
        endcase
        return r;
    endfunction

    function automatic logic mapped(input logic [11:0] a);
        return (a == `PCR_OFF_STATUS) || (a == `PCR_OFF_CONFIG) ||
               (a == `PCR_OFF_XADDR) || (a == `PCR_OFF_XDATA);
    endfunction

    always_comb
    begin
        logic wr_go;
        logic [31:0] wv;
        logic sw_xaddr;
        logic sw_xdata;
        logic [3:0] pend;
        logic any_trap;
        s_next = s_reg;
        wr_go = 1'b0;
        wv = 32'h0000_0000;
        sw_xaddr = 1'b0;
        sw_xdata = 1'b0;
        pend = 4'h0;
        any_trap = 1'b0;
        // pin synchroniser: first stage feeds only the second
        s_next.irq_s1 = ext_irq_lines;
        s_next.irq_s2 = s_reg.irq_s1;
        s_next.irq_s3 = s_reg.irq_s2;
        // write channel: address and data accepted in either order
        if (s_reg.awready && s_axi_awvalid)
        begin
            s_next.aw_held = 1'b1;
            s_next.aw_addr = s_axi_awaddr;
            s_next.awready = 1'b0;
        end
        if (s_reg.wready && s_axi_wvalid)
        begin
            s_next.w_held = 1'b1;
            s_next.w_data = s_axi_wdata;
            s_next.w_strb = s_axi_wstrb;
            s_next.wready = 1'b0;
        end
        if (s_reg.aw_held && s_reg.w_held && !s_reg.bvalid)
        begin
            wr_go = 1'b1;
            s_next.bvalid = 1'b1;
            s_next.bresp = mapped(s_reg.aw_addr) ? `PCR_RESP_OKAY : `PCR_RESP_SLVERR;
            s_next.aw_held = 1'b0;
            s_next.w_held = 1'b0;
        end
        if (s_reg.bvalid && s_axi_bready)
        begin
            s_next.bvalid = 1'b0;
            s_next.awready = 1'b1;
            s_next.wready = 1'b1;
        end
        if (s_reg.arready && s_axi_arvalid)
        begin
            s_next.arready = 1'b0;
            s_next.rvalid = 1'b1;
            s_next.rdata = read_word(s_reg, s_axi_araddr);
            s_next.rresp = mapped(s_axi_araddr) ? `PCR_RESP_OKAY : `PCR_RESP_SLVERR;
        end
        if (s_reg.rvalid && s_axi_rready)
        begin
            s_next.rvalid = 1'b0;
            s_next.arready = 1'b1;
        end
        if (wr_go)
        begin
            unique case (s_reg.aw_addr)
                `PCR_OFF_STATUS:
                begin
                    wv = merge(read_word(s_reg, `PCR_OFF_STATUS), s_reg.w_data, s_reg.w_strb)
                         & `PCR_STS_WMASK;
                    s_next.freeze_flag = wv[10];
                    s_next.interrupt_priority_mask = wv[3:2];
                    s_next.ext_irq_mask_all = wv[1];
                    s_next.global_event_block = wv[0];
                end
                `PCR_OFF_CONFIG:
                begin
                    // release level never written
                    wv = merge(read_word(s_reg, `PCR_OFF_CONFIG), s_reg.w_data, s_reg.w_strb)
                         & `PCR_CFG_WMASK;
                    s_next.cfg = wv[7:0];
                end
                `PCR_OFF_XADDR:
                begin
                    sw_xaddr = 1'b1;
                    s_next.xfer_addr_capture = merge(s_reg.xfer_addr_capture,
                                                     s_reg.w_data, s_reg.w_strb);
                end
                `PCR_OFF_XDATA:
                begin
                    sw_xdata = 1'b1;
                    s_next.xfer_data_capture = merge(s_reg.xfer_data_capture,
                                                     s_reg.w_data, s_reg.w_strb);
                end
                default:
                begin
                    wv = 32'h0000_0000;
                end
            endcase
        end
        // a level change counts only once stages two and three agree, so a glitch is dropped
        for (int i = 0; i < 4; i++)
        begin
            if (s_reg.irq_s2[i] == s_reg.irq_s3[i])
            begin
                s_next.irq_lvl[i] = s_reg.irq_s3[i];
            end
        end
        pend = s_reg.irq_lvl;
        // priority decode
        unique case (s_reg.interrupt_priority_mask)
            2'b00: s_next.irq_enable = 4'b0001;
            2'b01: s_next.irq_enable = 4'b0011;
            2'b10: s_next.irq_enable = 4'b0111;
            2'b11: s_next.irq_enable = 4'b1111;
        endcase
        // external lines: mask-all and global block gate them
        s_next.irq_take = (|(pend & s_reg.irq_enable) && !s_reg.ext_irq_mask_all &&
                           !s_reg.global_event_block) ||
                          ((timer_irq || trace_trap) && !s_reg.global_event_block);
        any_trap = trap_req || ext_trap || urgent_trap;
        s_next.trap_take = urgent_trap || (any_trap && !s_reg.global_event_block);
        s_next.monitor_enter = s_reg.global_event_block &&
                               (breakpoint || urgent_trap || trap_req);
        s_next.user_check = user_rights_override;
        s_next.coproc_trap = ldst_coproc && !s_reg.cfg.coproc_present;
        s_next.narrow_hw = ldst_narrow && s_reg.cfg.narrow_access_en;
        // the effective disable only follows the register at a branch
        if (branch_exec)
        begin
            s_next.jump_cache_off_eff = s_reg.cfg.jump_cache_off;
        end
        // capture, skipped while frozen; a bus write in the same cycle wins
        if (xfer.valid && !s_reg.freeze_flag)
        begin
            if (!sw_xaddr)
            begin
                s_next.xfer_addr_capture = xfer.to_coproc ? xfer.data :
                                           (xfer.xlate_en ? xfer.vaddr : xfer.paddr);
            end
            if (!sw_xdata)
            begin
                s_next.xfer_data_capture = xfer.data; // loads leave junk here
            end
        end
        // taking an event sets freeze, over any software clear
        if (s_reg.irq_take || s_reg.trap_take)
        begin
            s_next.freeze_flag = 1'b1;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_reg <= '0;
            s_reg.awready <= 1'b1;
            s_reg.wready <= 1'b1;
            s_reg.arready <= 1'b1;
            s_reg.cfg <= `PCR_CFG_RESET;
            s_reg.jump_cache_off_eff <= 1'b1;
            s_reg.irq_enable <= 4'b0001;
        end
        else
        begin
            s_reg <= s_next;
        end
    end

    assign s_axi_awready = s_reg.awready;
    assign s_axi_wready = s_reg.wready;
    assign s_axi_bvalid = s_reg.bvalid;
    assign s_axi_bresp = s_reg.bresp;
    assign s_axi_arready = s_reg.arready;
    assign s_axi_rvalid = s_reg.rvalid;
    assign s_axi_rdata = s_reg.rdata;
    assign s_axi_rresp = s_reg.rresp;
    assign cfg_out = s_reg.cfg;
    assign jump_cache_off_eff = s_reg.jump_cache_off_eff;
    assign irq_enable = s_reg.irq_enable;
    assign irq_take = s_reg.irq_take;
    assign trap_take = s_reg.trap_take;
    assign monitor_enter = s_reg.monitor_enter;
    assign user_check = s_reg.user_check;
    assign coproc_trap = s_reg.coproc_trap;
    assign narrow_hw = s_reg.narrow_hw;
    assign freeze_flag = s_reg.freeze_flag;
endmodule
`default_nettype wire

/* File: dv/pcr_bank_checker.sv */
// concurrent checks on the ports of the processor control register bank
`timescale 1ns/1ps
`default_nettype none
module pcr_bank_checker (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_awready,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic trap_req,
    input wire logic urgent_trap,
    input wire logic ext_trap,
    input wire logic breakpoint,
    input wire logic branch_exec,
    input wire logic user_rights_override,
    input wire logic ldst_coproc,
    input wire logic ldst_narrow,
    input wire pcr_pkg::pcr_cfg_t cfg_out,
    input wire logic jump_cache_off_eff,
    input wire logic irq_take,
    input wire logic trap_take,
    input wire logic monitor_enter,
    input wire logic user_check,
    input wire logic coproc_trap,
    input wire logic narrow_hw,
    input wire logic freeze_flag
);
    import pcr_pkg::*;
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped early");
    rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped early");
    read_latency_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    aw_refused_a: assert property (s_axi_bvalid |-> !s_axi_awready)
        else $error("write address taken while response pending");
    w_refused_a: assert property (s_axi_bvalid |-> !s_axi_wready)
        else $error("write data taken while response pending");
    ar_refused_a: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read address taken while data pending");
    // the applied disable may only move after a branch
    cache_eff_a: assert property ($changed(jump_cache_off_eff) |-> $past(branch_exec))
        else $error("jump cache disable applied without branch");
    cache_follow_a: assert property (branch_exec |=>
        jump_cache_off_eff == $past(cfg_out.jump_cache_off)) else $error("branch missed cfg");
    coproc_trap_a: assert property (coproc_trap |->
        $past(ldst_coproc && !cfg_out.coproc_present)) else $error("spurious coproc trap");
    narrow_hw_a: assert property (narrow_hw |->
        $past(ldst_narrow && cfg_out.narrow_access_en)) else $error("spurious narrow access");
    user_check_a: assert property (user_check |-> $past(user_rights_override))
        else $error("spurious user check");
    freeze_set_a: assert property (irq_take || trap_take |-> ##[0:1] freeze_flag)
        else $error("freeze not set on event");
    monitor_cause_a: assert property (monitor_enter |->
        $past(breakpoint || trap_req || urgent_trap))
        else $error("monitor entered without cause");
    ext_no_monitor_a: assert property (ext_trap && !trap_req && !urgent_trap &&
        !breakpoint |=> !monitor_enter) else $error("monitor entered on external trap");
endmodule
bind pcr_bank pcr_bank_checker i_chk (.*);
`default_nettype wire

/* File: dv/tb.sv */
// self-checking bench for the processor control register bank
`timescale 1ns/1ps
`default_nettype none
`include "pcr_defines.svh"
module tb;
    import pcr_pkg::*;
    localparam logic [11:0] ST = `PCR_OFF_STATUS;
    localparam logic [11:0] CF = `PCR_OFF_CONFIG;
    localparam logic [11:0] XA = `PCR_OFF_XADDR;
    localparam logic [11:0] XD = `PCR_OFF_XDATA;
    localparam logic [31:0] HI = {`PCR_RELEASE_LEVEL, 24'h0};
    logic aclk = 0;
    logic aresetn = 0;
    logic [11:0] s_axi_awaddr = 0, s_axi_araddr = 0;
    logic [31:0] s_axi_wdata = 0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'hf, ext_irq_lines = 0, irq_enable;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic s_axi_arvalid = 0, s_axi_rready = 0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic trap_req, urgent_trap, ext_trap, breakpoint, branch_exec;
    logic user_rights_override, ldst_coproc, ldst_narrow;
    // timer and trace events only show on irq_take
    logic timer_irq = 0, trace_trap = 0;
    pcr_xfer_t xfer = '0;
    pcr_cfg_t cfg_out;
    logic jump_cache_off_eff, irq_take, trap_take, monitor_enter;
    logic user_check, coproc_trap, narrow_hw, freeze_flag;
    logic [7:0] evv = 0;
    int mismatches = 0;
    int check_count = 0;
    int seed = 37;
    int i;
    logic [33:0] rq [$];
    logic [1:0] bq [$];
    logic [31:0] d, va, pa, dt;
    // status low nibble, event inputs, irq lines, expected seen outputs
    logic [21:0] tbl [15] = '{
        {4'h0, 8'h00, 4'h2, 6'h00},
        {4'h0, 8'h00, 4'h1, 6'h20},
        {4'hc, 8'h00, 4'h8, 6'h20},
        {4'h4, 8'h00, 4'h4, 6'h00},
        {4'he, 8'h00, 4'hf, 6'h00},
        {4'he, 8'h80, 4'hf, 6'h10},
        {4'hd, 8'h00, 4'hf, 6'h00},
        {4'hd, 8'h80, 4'h0, 6'h08},
        {4'hd, 8'hc0, 4'h0, 6'h18},
        {4'hd, 8'h10, 4'h0, 6'h08},
        {4'hd, 8'h20, 4'h0, 6'h00},
        {4'h0, 8'h04, 4'h0, 6'h04},
        {4'h0, 8'h02, 4'h0, 6'h02},
        {4'h0, 8'h01, 4'h0, 6'h00},
        {4'h0, 8'h80, 4'h0, 6'h10}};
    assign {trap_req, urgent_trap, ext_trap, breakpoint} = evv[7:4];
    assign {branch_exec, user_rights_override, ldst_coproc, ldst_narrow} = evv[3:0];
    pcr_bank i_dut (.*);
    initial forever #50 aclk = ~aclk;
    task automatic chk(string n, logic [33:0] e, logic [33:0] g);
        check_count++;
        if (g !== e)
        begin
            mismatches++;
            $display("unexpected %s exp %h got %h", n, e, g);
        end
    endtask
    task automatic wr(logic [11:0] a, logic [31:0] v, logic [1:0] r = 2'b00);
        bq.push_back(r);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_awvalid <= 1;
        s_axi_wdata <= v;
        s_axi_wvalid <= 1;
        s_axi_bready <= 1;
        do
        begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 0;
            if (s_axi_wready) s_axi_wvalid <= 0;
        end while (!s_axi_bvalid);
        s_axi_bready <= 0;
    endtask
    task automatic rd(logic [11:0] a, logic [31:0] v, logic [1:0] r = 2'b00);
        rq.push_back({r, v});
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1;
        s_axi_rready <= 1;
        do
        begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 0;
        end while (!s_axi_rvalid);
        s_axi_rready <= 0;
    endtask
    // results arrive later than the requests, so they are matched in order
    always @(posedge aclk)
    begin
        if (s_axi_rvalid && s_axi_rready) chk("read", rq.pop_front(), {s_axi_rresp, s_axi_rdata});
        if (s_axi_bvalid && s_axi_bready) chk("bresp", bq.pop_front(), s_axi_bresp);
    end
    task automatic pulse(logic [3:0] st, logic [7:0] v, logic [3:0] irq, logic [5:0] e);
        logic [5:0] seen;
        seen = 0;
        wr(ST, {28'h0, st});
        @(posedge aclk);
        evv <= v;
        xfer.valid <= |v[2:0];
        ext_irq_lines <= irq;
        @(posedge aclk);
        evv <= 0;
        xfer.valid <= 0;
        repeat (8)
        begin
            @(posedge aclk);
            seen |= {irq_take, trap_take, monitor_enter, user_check, coproc_trap, narrow_hw};
        end
        ext_irq_lines <= 0;
        repeat (4) @(posedge aclk);
        chk("events", e, seen);
    endtask
    task automatic xf(logic [2:0] f);
        va = $random(seed);
        pa = $random(seed);
        dt = $random(seed);
        @(posedge aclk);
        xfer <= {1'b1, f, va, pa, dt};
        @(posedge aclk);
        xfer.valid <= 0;
    endtask
    task end_of_test;
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    initial
    begin
        repeat (20000) @(posedge aclk);
        mismatches++;
        end_of_test;
    end
    initial
    begin
        repeat (4) @(posedge aclk);
        aresetn <= 1;
        rd(ST, 0);
        rd(CF, HI | `PCR_CFG_RESET);
        rd(XA, 0);
        rd(XD, 0);
        rd(12'h010, 0, `PCR_RESP_SLVERR);
        wr(12'h010, 32'h5a, `PCR_RESP_SLVERR);
        chk("cfg_out", `PCR_CFG_RESET, cfg_out);
        chk("cache_eff", 1, jump_cache_off_eff);
        $display("test reset done");
        for (i = 0; i < 8; i++)
        begin
            d = $random(seed);
            d[7:0] = 8'h1 << i;
            wr(CF, d);
            rd(CF, HI | d[7:0]);
            chk("cfg_out", d[7:0], cfg_out);
        end
        $display("test config done");
        chk("cache_eff", 1, jump_cache_off_eff);
        pulse(0, 8'h08, 0, 0);
        chk("cache_eff", 0, jump_cache_off_eff);
        wr(CF, 1);
        chk("cache_eff", 0, jump_cache_off_eff);
        pulse(0, 8'h08, 0, 0);
        chk("cache_eff", 1, jump_cache_off_eff);
        $display("test branch done");
        for (i = 0; i < 4; i++)
        begin
            wr(ST, i << 2);
            @(posedge aclk);
            chk("irq_enable", (5'h2 << i) - 1, irq_enable);
        end
        $display("test decode done");
        for (i = 0; i < 15; i++)
            pulse(tbl[i][21:18], tbl[i][17:10], tbl[i][9:6], tbl[i][5:0]);
        rd(ST, 32'h400);
        wr(CF, 32'h22);
        pulse(0, 8'h02, 0, 0);
        pulse(0, 8'h01, 0, 6'h01);
        wr(ST, 32'h2);
        @(posedge aclk);
        timer_irq <= 1;
        @(posedge aclk);
        timer_irq <= 0;
        @(posedge aclk);
        chk("timer", 1, irq_take);
        wr(ST, 32'h1);
        @(posedge aclk);
        trace_trap <= 1;
        @(posedge aclk);
        trace_trap <= 0;
        @(posedge aclk);
        chk("trace", 0, irq_take);
        $display("test events done");
        wr(ST, 0);
        xf(3'b001);
        rd(XA, va);
        rd(XD, dt);
        xf(3'b000);
        rd(XA, pa);
        xf(3'b010);
        rd(XA, dt);
        rd(XD, dt);
        xf(3'b100);
        rd(XA, pa);
        d = pa;
        wr(ST, 32'h400);
        xf(3'b001);
        rd(XA, d);
        wr(XD, va);
        rd(XD, va);
        $display("test capture done");
        end_of_test;
    end
endmodule
`default_nettype wire
